// [common/gain_ctrl_pkg.sv]
// gain controller constants: register map, field positions, gain limits,
// reset values and pacing times. shared by the controller and its helpers.
package gain_ctrl_pkg;

  // ---------------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------------
  localparam logic [7:0] ANALOG_SETTINGS_ONE_ADDR = 8'h15;
  localparam logic [7:0] GAIN_STATUS_ADDR         = 8'h16;
  localparam logic [7:0] UNMAPPED_READ_VAL        = 8'h00;

  // analog_settings_one field positions
  localparam int AUTO_GAIN_SELECT_BIT    = 7;
  localparam int GAIN_CEILING_ENABLE_BIT = 6;
  localparam int GAIN_INCREMENT_CMD_BIT  = 5;
  localparam int GAIN_DECREMENT_CMD_BIT  = 4;
  localparam int ANALOG_SLEEP_BIT        = 3;

  // reset values of the stored fields
  localparam logic ANALOG_SLEEP_RST        = 1'b0;
  localparam logic AUTO_GAIN_SELECT_RST    = 1'b0;
  localparam logic GAIN_CEILING_ENABLE_RST = 1'b0;

  // ---------------------------------------------------------------------
  // gain step index: 32 positions spanning -4 dB .. +12 dB
  // ---------------------------------------------------------------------
  localparam int         GAIN_STEPS    = 32;
  localparam int         GAIN_W        = 5;
  localparam logic [4:0] GAIN_MIN_IDX  = 5'h00;
  localparam logic [4:0] GAIN_MAX_IDX  = 5'h1F;
  // 7.66 dB sits at step 22 of the -4..+12 dB span
  localparam logic [4:0] GAIN_CEIL_IDX = 5'h16;
  // close to 0 dB
  localparam logic [4:0] GAIN_RST_IDX  = 5'h08;

  // ---------------------------------------------------------------------
  // pacing: step time constants at over-speed factor one
  // ---------------------------------------------------------------------
  localparam int CLK_MHZ       = 250;
  localparam int RAISE_TC_US   = 1000;
  localparam int LOWER_TC_US   = 60;
  localparam int RAISE_TC_CYC  = RAISE_TC_US * CLK_MHZ;
  localparam int LOWER_TC_CYC  = LOWER_TC_US * CLK_MHZ;
  localparam int CLIP_WIN_SAMP = 256;
  // clipping limit as a fraction: over 1/5 of the window
  localparam int CLIP_DIVISOR  = 5;
  localparam logic [7:0] ADC_CODE_LOW  = 8'h00;
  localparam logic [7:0] ADC_CODE_HIGH = 8'hFF;

  // automatic controller states
  typedef enum logic [1:0] {
    AGC_HOLD  = 2'b00,
    AGC_RAISE = 2'b01,
    AGC_KEEP  = 2'b10,
    AGC_LOWER = 2'b11
  } agc_state_t;

endpackage : gain_ctrl_pkg

// [design/adc_code_monitor.sv]
// adc code monitor: over a fixed window of samples, counts extreme codes
// and reports whether full scale was seen and whether clipping was heavy.
// assumes samples arrive synchronous to mclk_i with a valid strobe.
`timescale 1ns/1ps
`default_nettype none
module adc_code_monitor #(
  parameter int unsigned WINDOW = 256
) (
  input  wire logic       mclk_i,
  input  wire logic       rst_b_i,
  input  wire logic [7:0] adc_data_i,
  input  wire logic       adc_valid_i,
  output logic            done_o,
  output logic            full_scale_o,
  output logic            over_clip_o
);

  logic [31:0] samp_cnt_r;
  logic [31:0] clip_cnt_r;
  logic        extreme;
  logic [31:0] clip_tot;

  // all-zero or all-one codes mark the converter's extremes
  assign extreme  = (adc_data_i == gain_ctrl_pkg::ADC_CODE_LOW) ||
                    (adc_data_i == gain_ctrl_pkg::ADC_CODE_HIGH);
  assign clip_tot = clip_cnt_r + {31'h0, extreme};

  // ---------------------------------------------------------------------
  // window counting; verdict latched at the last sample of the window
  // ---------------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      samp_cnt_r   <= 32'h0;
      clip_cnt_r   <= 32'h0;
      done_o       <= 1'b0;
      full_scale_o <= 1'b0;
      over_clip_o  <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (adc_valid_i) begin
        if (samp_cnt_r == WINDOW - 1) begin
          samp_cnt_r   <= 32'h0;
          clip_cnt_r   <= 32'h0;
          done_o       <= 1'b1;
          full_scale_o <= (clip_tot != 32'h0);
          // times five avoids a divider for the 20% limit
          over_clip_o  <= (clip_tot * gain_ctrl_pkg::CLIP_DIVISOR) > WINDOW;
        end else begin
          samp_cnt_r <= samp_cnt_r + 32'h1;
          clip_cnt_r <= clip_tot;
        end
      end
    end
  end

endmodule : adc_code_monitor
`default_nettype wire

// [design/hf_adc_gain_control.sv]
// gain controller for the variable-gain amplifier ahead of the hf adc:
// register port, manual step commands, automatic tracking of adc codes.
// assumes all inputs synchronous to mclk_i; reset is synchronised here.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - over 20% extreme codes lower gain, none raise it
// - gain is a 32-position step index
// - write with bit 5 steps gain up
// - write with bit 4 steps gain down
// - steps ignored at lower or upper limit
// - auto raise paced 1000/n us without full scale
// - auto keeps gain while clipping within 20%
// - auto lower paced 60/n us above 20%
// - bit 7 selects hold or automatic mode
// - bit 6 caps gain raises at 7.66 dB
// - bit 3 drives analog power-down request
// - settings register write-only at 15H
module hf_adc_gain_control #(
  parameter int unsigned RAISE_CYC = gain_ctrl_pkg::RAISE_TC_CYC,
  parameter int unsigned LOWER_CYC = gain_ctrl_pkg::LOWER_TC_CYC,
  parameter int unsigned CLIP_WIN  = gain_ctrl_pkg::CLIP_WIN_SAMP
) (
  input  wire logic       mclk_i,
  input  wire logic       rst_b_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic [7:0] adc_data_i,
  input  wire logic       adc_valid_i,
  input  wire logic [3:0] overspeed_i,
  output logic      [4:0] gain_idx_o,
  output logic            analog_sleep_o
);

  // ---------------------------------------------------------------------
  // reset synchroniser
  // ---------------------------------------------------------------------
  logic rst_meta_r;
  logic rst_sync_r;

  // release is delayed two edges; assertion stays asynchronous
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ---------------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------------
  logic       set_wr;
  logic       man_up;
  logic       man_dn;
  logic       auto_sel_r;
  logic       ceil_en_r;
  logic [4:0] gain_r;
  logic [4:0] gain_lim;
  logic       ceil_now;
  gain_ctrl_pkg::agc_state_t state_r;

  assign set_wr = wr_i && (addr_i == gain_ctrl_pkg::ANALOG_SETTINGS_ONE_ADDR);
  // both command bits set cancel each other out
  assign man_up = set_wr && wdata_i[gain_ctrl_pkg::GAIN_INCREMENT_CMD_BIT] &&
                  !wdata_i[gain_ctrl_pkg::GAIN_DECREMENT_CMD_BIT];
  assign man_dn = set_wr && wdata_i[gain_ctrl_pkg::GAIN_DECREMENT_CMD_BIT] &&
                  !wdata_i[gain_ctrl_pkg::GAIN_INCREMENT_CMD_BIT];

  // stored fields take effect on the write; bits 2..0 are not kept
  always_ff @(posedge mclk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      auto_sel_r     <= gain_ctrl_pkg::AUTO_GAIN_SELECT_RST;
      ceil_en_r      <= gain_ctrl_pkg::GAIN_CEILING_ENABLE_RST;
      analog_sleep_o <= gain_ctrl_pkg::ANALOG_SLEEP_RST;
    end else if (set_wr) begin
      auto_sel_r     <= wdata_i[gain_ctrl_pkg::AUTO_GAIN_SELECT_BIT];
      ceil_en_r      <= wdata_i[gain_ctrl_pkg::GAIN_CEILING_ENABLE_BIT];
      analog_sleep_o <= wdata_i[gain_ctrl_pkg::ANALOG_SLEEP_BIT];
    end
  end

  // ---------------------------------------------------------------------
  // read port: settings register reads zero, status shows live state
  // ---------------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      rdata_o <= gain_ctrl_pkg::UNMAPPED_READ_VAL;
    end else if (rd_i && addr_i == gain_ctrl_pkg::GAIN_STATUS_ADDR) begin
      rdata_o <= {state_r, ceil_en_r, gain_r};
    end else begin
      // write-only and unmapped locations read as zero
      rdata_o <= gain_ctrl_pkg::UNMAPPED_READ_VAL;
    end
  end

  // ---------------------------------------------------------------------
  // adc code monitor and step pacers
  // ---------------------------------------------------------------------
  logic win_done;
  logic full_scale;
  logic over_clip;
  logic raise_tick;
  logic lower_tick;

  adc_code_monitor #(
    .WINDOW (CLIP_WIN)
  ) u_monitor (
    .mclk_i       (mclk_i),
    .rst_b_i      (rst_sync_r),
    .adc_data_i   (adc_data_i),
    .adc_valid_i  (adc_valid_i),
    .done_o       (win_done),
    .full_scale_o (full_scale),
    .over_clip_o  (over_clip)
  );

  // pacing follows the over-speed factor: time constants shrink by n
  step_pacer #(
    .BASE_PERIOD (RAISE_CYC)
  ) u_raise_pacer (
    .mclk_i  (mclk_i),
    .rst_b_i (rst_sync_r),
    .run_i   (state_r == gain_ctrl_pkg::AGC_RAISE),
    .speed_i (overspeed_i),
    .tick_o  (raise_tick)
  );

  step_pacer #(
    .BASE_PERIOD (LOWER_CYC)
  ) u_lower_pacer (
    .mclk_i  (mclk_i),
    .rst_b_i (rst_sync_r),
    .run_i   (state_r == gain_ctrl_pkg::AGC_LOWER),
    .speed_i (overspeed_i),
    .tick_o  (lower_tick)
  );

  // ---------------------------------------------------------------------
  // automatic mode state machine, re-judged at each window end
  // ---------------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      state_r <= gain_ctrl_pkg::AGC_HOLD;
    end else if (!auto_sel_r) begin
      state_r <= gain_ctrl_pkg::AGC_HOLD;
    end else begin
      unique case (state_r)
        gain_ctrl_pkg::AGC_HOLD: begin
          // start by raising until the first verdict arrives
          state_r <= gain_ctrl_pkg::AGC_RAISE;
        end
        gain_ctrl_pkg::AGC_RAISE,
        gain_ctrl_pkg::AGC_KEEP,
        gain_ctrl_pkg::AGC_LOWER: begin
          if (win_done) begin
            if (!full_scale) begin
              state_r <= gain_ctrl_pkg::AGC_RAISE;
            end else if (over_clip) begin
              state_r <= gain_ctrl_pkg::AGC_LOWER;
            end else begin
              state_r <= gain_ctrl_pkg::AGC_KEEP;
            end
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // gain step index
  // ---------------------------------------------------------------------
  logic step_up;
  logic step_dn;

  // a write's own ceiling bit counts at once, so the write that sets it
  // cannot carry a step past the ceiling
  assign ceil_now = set_wr ? wdata_i[gain_ctrl_pkg::GAIN_CEILING_ENABLE_BIT]
                           : ceil_en_r;

  // ceiling clips raises only; a gain already above it is not pulled down
  assign gain_lim = ceil_now ? gain_ctrl_pkg::GAIN_CEIL_IDX
                             : gain_ctrl_pkg::GAIN_MAX_IDX;

  // a manual write owns its cycle so an auto tick cannot cancel it;
  // ticks are gated by the mode bit since the state lags it one cycle
  assign step_up = set_wr ? man_up
                 : auto_sel_r && (state_r == gain_ctrl_pkg::AGC_RAISE) &&
                   raise_tick;
  assign step_dn = set_wr ? man_dn
                 : auto_sel_r && (state_r == gain_ctrl_pkg::AGC_LOWER) &&
                   lower_tick;

  always_ff @(posedge mclk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      gain_r <= gain_ctrl_pkg::GAIN_RST_IDX;
    end else if (step_up && gain_r < gain_lim) begin
      gain_r <= gain_r + 5'h01;
    end else if (step_dn && gain_r > gain_ctrl_pkg::GAIN_MIN_IDX) begin
      gain_r <= gain_r - 5'h01;
    end
  end

  assign gain_idx_o = gain_r;

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_sync_r);

  AST_GAIN_RANGE: assert property (gain_r <= gain_ctrl_pkg::GAIN_MAX_IDX)
    else $error("gain index out of range");

  AST_MAN_UP: assert property (
    man_up && gain_r < gain_lim |=> gain_r == $past(gain_r) + 5'h01)
    else $error("increment write did not add one step");

  AST_MAN_DN: assert property (
    man_dn && gain_r != 5'h00 |=> gain_r == $past(gain_r) - 5'h01)
    else $error("decrement write did not remove one step");

  AST_AT_LIMIT: assert property (
    (man_up && gain_r == gain_lim) || (man_dn && gain_r == 5'h00)
    |=> $stable(gain_r))
    else $error("step taken past a gain limit");

  AST_AUTO_RAISE: assert property (
    auto_sel_r && state_r == gain_ctrl_pkg::AGC_RAISE && raise_tick && !set_wr &&
    gain_r < gain_lim |=> gain_r == $past(gain_r) + 5'h01)
    else $error("auto raise tick did not step up");

  AST_KEEP: assert property (
    state_r == gain_ctrl_pkg::AGC_KEEP && !set_wr |=> $stable(gain_r))
    else $error("gain moved while keeping");

  AST_AUTO_LOWER: assert property (
    auto_sel_r && state_r == gain_ctrl_pkg::AGC_LOWER && lower_tick && !set_wr &&
    gain_r != 5'h00 |=> gain_r == $past(gain_r) - 5'h01)
    else $error("auto lower tick did not step down");

  AST_HOLD: assert property (
    !auto_sel_r && !set_wr |=> $stable(gain_r))
    else $error("gain moved in hold mode");

  AST_CEIL: assert property (
    ceil_en_r && gain_r <= gain_ctrl_pkg::GAIN_CEIL_IDX && !set_wr
    |=> gain_r <= gain_ctrl_pkg::GAIN_CEIL_IDX)
    else $error("gain raised above ceiling");

  AST_SLEEP: assert property (
    set_wr |=> analog_sleep_o == $past(wdata_i[gain_ctrl_pkg::ANALOG_SLEEP_BIT]))
    else $error("power-down request not taken from write");

  AST_WO_READ: assert property (
    rd_i && addr_i == gain_ctrl_pkg::ANALOG_SETTINGS_ONE_ADDR |=> rdata_o == 8'h00)
    else $error("write-only register read non-zero");

  // ---------------------------------------------------------------------
  // decision, ceiling-write and read-port checks
  // ---------------------------------------------------------------------
  AST_MODE_OFF: assert property (
    !auto_sel_r |=> state_r == gain_ctrl_pkg::AGC_HOLD)
    else $error("state left hold while automatic mode was off");

  AST_TO_RAISE: assert property (
    auto_sel_r && state_r != gain_ctrl_pkg::AGC_HOLD && win_done && !full_scale
    |=> state_r == gain_ctrl_pkg::AGC_RAISE)
    else $error("window without full scale did not select raising");

  AST_TO_KEEP: assert property (
    auto_sel_r && state_r != gain_ctrl_pkg::AGC_HOLD && win_done && full_scale &&
    !over_clip |=> state_r == gain_ctrl_pkg::AGC_KEEP)
    else $error("light clipping window did not select keeping");

  AST_TO_LOWER: assert property (
    auto_sel_r && state_r != gain_ctrl_pkg::AGC_HOLD && win_done && full_scale &&
    over_clip |=> state_r == gain_ctrl_pkg::AGC_LOWER)
    else $error("heavy clipping window did not select lowering");

  AST_CEIL_WRITE: assert property (
    set_wr && wdata_i[gain_ctrl_pkg::GAIN_CEILING_ENABLE_BIT] &&
    gain_r <= gain_ctrl_pkg::GAIN_CEIL_IDX |=> gain_r <= gain_ctrl_pkg::GAIN_CEIL_IDX)
    else $error("gain stepped past a ceiling set by the same write");

  AST_RD_IDLE: assert property (
    !rd_i |=> rdata_o == gain_ctrl_pkg::UNMAPPED_READ_VAL)
    else $error("read data stood outside the read answer cycle");

  // main scenarios: both paced directions, keeping, upper gain limit and ceiling
  COV_RAISE: cover property (state_r == gain_ctrl_pkg::AGC_RAISE && raise_tick);
  COV_LOWER: cover property (state_r == gain_ctrl_pkg::AGC_LOWER && lower_tick);
  COV_KEEP:  cover property (state_r == gain_ctrl_pkg::AGC_KEEP);
  COV_TOP:   cover property (man_up && gain_r == gain_lim);
  COV_CEIL:  cover property (ceil_en_r && man_up && gain_r == gain_ctrl_pkg::GAIN_CEIL_IDX);

endmodule : hf_adc_gain_control
`default_nettype wire

// [design/step_pacer.sv]
// step pacer: emits one-cycle ticks spaced base_period/n clocks apart.
// assumes one clock, reset already synchronised by the caller.
`timescale 1ns/1ps
`default_nettype none
module step_pacer #(
  parameter int unsigned BASE_PERIOD = 15000
) (
  input  wire logic       mclk_i,
  input  wire logic       rst_b_i,
  input  wire logic       run_i,
  input  wire logic [3:0] speed_i,
  output logic            tick_o
);

  logic [31:0] acc_r;
  logic [31:0] inc;

  // n of zero is treated as one so the pacer never stalls
  assign inc = (speed_i == 4'h0) ? 32'h1 : {28'h0, speed_i};

  // ---------------------------------------------------------------------
  // accumulate n per clock; clearing at the base period gives base/n spacing, rounded up
  // ---------------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      acc_r  <= 32'h0;
      tick_o <= 1'b0;
    end else if (!run_i) begin
      acc_r  <= 32'h0;
      tick_o <= 1'b0;
    end else if (acc_r + inc >= BASE_PERIOD) begin
      acc_r  <= 32'h0;
      tick_o <= 1'b1;
    end else begin
      acc_r  <= acc_r + inc;
      tick_o <= 1'b0;
    end
  end

endmodule : step_pacer
`default_nettype wire

// [verification/adc_source_model.sv]
// adc sample source standing in for the gain amplifier and converter.
// assumes the bench sets mode and pace synchronous to mclk_i.
`timescale 1ns/1ps
`default_nettype none
module adc_source_model (
  input  wire logic       mclk_i,
  input  wire logic       rst_b_i,
  input  wire logic [1:0] mode_i,
  input  wire logic       slow_i,
  output logic      [7:0] adc_data_o,
  output logic            adc_valid_o
);
  // ---------------------------------------------------------------
  // sample pattern, repeating every eight samples
  // ---------------------------------------------------------------
  logic [2:0] phase_r;
  logic       gap_r;
  logic [7:0] code_nxt;

  // mode 0 mid codes only, 1 one extreme in eight, 2 four in eight
  always_comb begin
    case (mode_i)
      2'h1:    code_nxt = (phase_r == 3'h0) ? 8'hFF : 8'h80;
      2'h2:    code_nxt = phase_r[1] ? 8'h80 : (phase_r[0] ? 8'h00 : 8'hFF);
      default: code_nxt = 8'h40 + {5'h00, phase_r};
    endcase
  end

  // slow pace skips every other cycle; idle data is inverted so a
  // stale code never passes for a fresh sample
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      phase_r     <= 3'h0;
      gap_r       <= 1'b0;
      adc_data_o  <= 8'h80;
      adc_valid_o <= 1'b0;
    end else if (slow_i && !gap_r) begin
      gap_r       <= 1'b1;
      adc_valid_o <= 1'b0;
      adc_data_o  <= ~adc_data_o;
    end else begin
      gap_r       <= 1'b0;
      adc_valid_o <= 1'b1;
      adc_data_o  <= code_nxt;
      phase_r     <= phase_r + 3'h1;
    end
  end
endmodule : adc_source_model
`default_nettype wire

// [verification/tb_hf_adc_gain_control.sv]
// self-checking bench for the hf adc gain controller.
// assumes pacing and window shortened through the design parameters.
`timescale 1ns/1ps
`default_nettype none
module tb_hf_adc_gain_control;
  localparam int RAISE_N = 40;
  localparam int LOWER_N = 12;

  typedef struct {
    logic [7:0] a;
    logic [7:0] d;
    logic [4:0] g;
    logic       s;
  } row_t;

  logic       mclk_i;
  logic       rst_b_i;
  logic [7:0] addr_i;
  logic [7:0] wdata_i;
  logic       wr_i;
  logic       rd_i;
  logic [7:0] rdata_o;
  logic [7:0] adc_data;
  logic       adc_valid;
  logic [3:0] overspeed_i;
  logic [4:0] gain_idx_o;
  logic       analog_sleep_o;
  logic [1:0] src_mode;
  logic       src_slow;
  logic [7:0] rd_val;
  logic [4:0] g_keep;
  int         fail_count;
  int         n_compared;

  // step up, step down, both, sleep, foreign address, clear
  row_t rows [6] = '{'{8'h15, 8'h20, 5'h09, 1'b0}, '{8'h15, 8'h10, 5'h08, 1'b0},
                     '{8'h15, 8'h30, 5'h08, 1'b0}, '{8'h15, 8'h08, 5'h08, 1'b1},
                     '{8'h14, 8'h20, 5'h08, 1'b1}, '{8'h15, 8'h00, 5'h08, 1'b0}};

  // clock, 4 ns period
  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end

  hf_adc_gain_control #(.RAISE_CYC(RAISE_N), .LOWER_CYC(LOWER_N), .CLIP_WIN(8)) dut (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .adc_data_i(adc_data),
    .adc_valid_i(adc_valid), .overspeed_i(overspeed_i), .gain_idx_o(gain_idx_o),
    .analog_sleep_o(analog_sleep_o));

  adc_source_model src (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .mode_i(src_mode), .slow_i(src_slow),
    .adc_data_o(adc_data), .adc_valid_o(adc_valid));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  // one-cycle write; returns in the cycle after the write edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_i  <= a;
    wdata_i <= d;  // low three bits always zero
    wr_i    <= 1'b1;
    @(posedge mclk_i);
    wr_i    <= 1'b0;
    @(negedge mclk_i);
  endtask : wr

  // one-cycle read; data taken in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge mclk_i);
    rd_i   <= 1'b0;
    @(negedge mclk_i);
    rd_val = rdata_o;
  endtask : rd

  // waits for a gain step, then times the next one in clocks
  task automatic step_gap(input string nm, input logic up, input int gap);
    logic [4:0] g;
    int         n;
    for (int k = 0; k < 2; k++) begin
      g = gain_idx_o;
      n = 0;
      while (gain_idx_o === g && n < 2000) begin
        @(negedge mclk_i);
        n++;
      end
      check({nm, " dir"}, {3'h0, up ? g + 5'h01 : g - 5'h01}, {3'h0, gain_idx_o});
    end
    check({nm, " gap"}, 8'(gap), 8'(n));
  endtask : step_gap

  task automatic end_sim;
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim

  // watchdog at 20000 clocks, far beyond the several hundred clocks the tests need
  initial begin
    #80000;
    fail_count++;
    end_sim();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_b_i     = 1'b0;
    addr_i      = 8'h00;
    wdata_i     = 8'h00;
    wr_i        = 1'b0;
    rd_i        = 1'b0;
    overspeed_i = 4'h1;
    src_mode    = 2'h0;
    src_slow    = 1'b0;
    fail_count  = 0;
    n_compared  = 0;
    repeat (4) @(posedge mclk_i);
    check("reset gain", 8'h08, {3'h0, gain_idx_o});
    check("reset sleep", 8'h00, {7'h00, analog_sleep_o});
    rst_b_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rd(8'h15);
    check("settings not readable", 8'h00, rd_val);
    rd(8'h16);
    check("status after reset", 8'h08, rd_val);
    @(negedge mclk_i);
    check("read data drops", 8'h00, rdata_o);
    $display("test reset done");

    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      check("row gain", {3'h0, rows[i].g}, {3'h0, gain_idx_o});
      check("row sleep", {7'h00, rows[i].s}, {7'h00, analog_sleep_o});
    end
    $display("test rows done");

    // limits: overshooting steps must saturate, not wrap
    repeat (9) wr(8'h15, 8'h10);
    check("low limit", 8'h00, {3'h0, gain_idx_o});
    repeat (33) wr(8'h15, 8'h20);
    check("high limit", 8'h1F, {3'h0, gain_idx_o});
    // at index 22 the write that enables the ceiling must not step past it
    repeat (9) wr(8'h15, 8'h10);
    repeat (4) wr(8'h15, 8'h60);
    check("ceiling", 8'h16, {3'h0, gain_idx_o});
    rd(8'h16);
    check("status ceiling", 8'h36, rd_val);
    $display("test limits done");

    // automatic raise with mid codes only, at two speed factors
    wr(8'h15, 8'h80);
    step_gap("raise n1", 1'b1, RAISE_N);
    @(posedge mclk_i);
    overspeed_i <= 4'h2;
    step_gap("raise n2", 1'b1, RAISE_N / 2);
    $display("test raise done");

    // light clipping, slow samples: gain must sit still
    @(posedge mclk_i);
    src_mode <= 2'h1;
    src_slow <= 1'b1;
    repeat (60) @(negedge mclk_i);
    g_keep = gain_idx_o;
    repeat (200) @(negedge mclk_i);
    check("keep gain", {3'h0, g_keep}, {3'h0, gain_idx_o});
    rd(8'h16);
    check("keep state", 8'h02, {6'h00, rd_val[7:6]});
    $display("test keep done");

    // heavy clipping lowers the gain at the short pace
    @(posedge mclk_i);
    src_mode    <= 2'h2;
    src_slow    <= 1'b0;
    overspeed_i <= 4'h0;  // factor zero paces as factor one
    step_gap("lower", 1'b0, LOWER_N);
    rd(8'h16);
    check("lower state", 8'h03, {6'h00, rd_val[7:6]});
    $display("test lower done");

    // hold mode freezes the gain despite heavy clipping
    wr(8'h15, 8'h00);
    g_keep = gain_idx_o;
    repeat (100) @(negedge mclk_i);
    check("hold gain", {3'h0, g_keep}, {3'h0, gain_idx_o});
    rd(8'h16);
    check("hold state", 8'h00, {6'h00, rd_val[7:6]});
    $display("test hold done");
    end_sim();
  end
endmodule : tb_hf_adc_gain_control
`default_nettype wire
